//--- issf_pkg.sv
// Purpose: shared constants of the serial bus status flag block
// Assumes: 8-bit register port, 3-bit register address
// Notes: bits 1 and 0 of the status register belong to logic outside this block
package issf_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int CNT_W = 4;

  // register addresses
  localparam logic [2:0] STATUS_ADDR = 3'h0;
  localparam logic [2:0] CTRL_ADDR = 3'h1;
  localparam logic [2:0] TX_HOLD_ADDR = 3'h2;
  localparam logic [2:0] RX_DATA_ADDR = 3'h3;
  localparam logic [2:0] IRQ_MASK_ADDR = 3'h4;

  // status register bit positions
  localparam int TX_HOLDING_EMPTY_BIT = 7;
  localparam int TX_END_FLAG_BIT = 6;
  localparam int RX_FULL_FLAG_BIT = 5;
  localparam int NACK_BIT = 4;
  localparam int STOP_BIT = 3;
  localparam int ALOVE_BIT = 2;

  // control register bit positions
  localparam int CTRL_FS_BIT = 0;
  localparam int CTRL_ACK_JUDGE_ENABLE_BIT = 1;
  localparam int CTRL_TRS_BIT = 2;
  localparam int CTRL_MST_BIT = 3;

  // reset values and field masks
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] STATUS_USED = 8'hFC;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_USED = 8'h0F;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] TX_HOLD_RST = 8'hFF;
  localparam logic [7:0] RX_DATA_RST = 8'hFF;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // format select encoding
  localparam logic FMT_I2C = 1'b0;
  localparam logic FMT_SYNC = 1'b1;

  // clocks per frame, acknowledge included for the two-wire format
  localparam int I2C_FRAME_BITS = 9;
  localparam int SYNC_FRAME_BITS = 8;
endpackage : issf_pkg

//--- issf_pin_if.sv
// Purpose: carries bus conditions from the pin monitor to the flag logic
// Assumes: all signals are on clk
// Notes: pulses last one clk cycle
`timescale 1ns/1ns
interface issf_pin_if;
  logic sclRise;
  logic sdaLevel;
  logic startSeen;
  logic stopSeen;
  modport det (output sclRise, output sdaLevel, output startSeen, output stopSeen);
  modport flags (input sclRise, input sdaLevel, input startSeen, input stopSeen);
endinterface : issf_pin_if

//--- issf_bus_monitor.sv
// Purpose: synchronises the bus pins and finds clock edges, start and stop
// Assumes: bus clock far slower than clk
// Notes: outputs lag the pins by three clk cycles
`timescale 1ns/1ns
module issf_bus_monitor (
  input wire logic clk, // core clock
  input wire logic reset, // synchronous reset, active high
  input wire logic sclPin, // bus clock pin
  input wire logic sdaPin, // bus data pin
  issf_pin_if.det mon // detected bus conditions
);
  logic sclMeta_ff;
  logic sclSync_ff;
  logic sclPrev_ff;
  logic sdaMeta_ff;
  logic sdaSync_ff;
  logic sdaPrev_ff;
  logic sclRise_ff;
  logic startSeen_ff;
  logic stopSeen_ff;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (reset) begin
      sclMeta_ff <= 1'b1;
      sclSync_ff <= 1'b1;
      sdaMeta_ff <= 1'b1;
      sdaSync_ff <= 1'b1;
    end else begin
      sclMeta_ff <= sclPin;
      sclSync_ff <= sclMeta_ff;
      sdaMeta_ff <= sdaPin;
      sdaSync_ff <= sdaMeta_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sclPrev_ff <= 1'b1;
      sdaPrev_ff <= 1'b1;
      sclRise_ff <= 1'b0;
      startSeen_ff <= 1'b0;
      stopSeen_ff <= 1'b0;
    end else begin
      sclPrev_ff <= sclSync_ff;
      sdaPrev_ff <= sdaSync_ff;
      sclRise_ff <= sclSync_ff & ~sclPrev_ff;
      // data edges only count while the clock stays high
      startSeen_ff <= sclSync_ff & sclPrev_ff & sdaPrev_ff & ~sdaSync_ff;
      stopSeen_ff <= sclSync_ff & sclPrev_ff & ~sdaPrev_ff & sdaSync_ff;
    end
  end

  assign mon.sclRise = sclRise_ff;
  assign mon.sdaLevel = sdaPrev_ff;
  assign mon.startSeen = startSeen_ff;
  assign mon.stopSeen = stopSeen_ff;
endmodule : issf_bus_monitor

//--- issf_status_flags.sv
// Contract
// - tx hold to shift sets holding-empty
// - transmit select, start, slave turnaround set holding-empty
// - tx holding write clears holding-empty, tx-end
// - two-wire: ninth clock rise sets tx-end
// - sync format: last bit sent sets tx-end
// - received byte moved sets rx-full
// - reading rx data clears rx-full
// - missing ack with judgment enabled sets no-ack
// - stop after frame sets stop flag
// - bit 2 meaning follows format
// - master transmit data mismatch sets arbitration lost
// - start seen while driving high sets lost
// - sync receive while rx-full sets overrun
// - no-ack, stop and bit 2 clear only by read-one-then-write-zero
// - format select chooses two-wire or sync
// - ack judgment halts transfer on no-ack
//
// Purpose: status flags of a two-wire / clock-synchronous serial interface
// Assumes: data path events arrive on clk as one-cycle pulses
// Notes: irq is registered, one cycle behind the flags
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ns
module issf_status_flags #(
  parameter int I2C_BITS = issf_pkg::I2C_FRAME_BITS, // clocks per two-wire frame
  parameter int SYNC_BITS = issf_pkg::SYNC_FRAME_BITS // clocks per sync frame
) (
  input wire logic clk, // core clock, 20 MHz
  input wire logic reset, // synchronous reset, active high
  input wire logic [2:0] regAddr, // register address
  input wire logic [7:0] regWrData, // register write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [7:0] regRdData, // read data, cycle after the strobe
  input wire logic sclPin, // bus clock pin level
  input wire logic sdaPin, // bus data pin level
  input wire logic sdaDriveHigh, // internal data level, high = released
  input wire logic txHoldToShift, // holding register moved into shift register
  input wire logic startIssued, // start or repeated start issued
  input wire logic slaveToTransmit, // slave turned from receive to transmit
  input wire logic rxLoad, // received byte moved to rx data register
  input wire logic [7:0] rxByte, // received byte
  output logic [7:0] txHoldData, // transmit holding register
  output logic txHoldWritten, // pulse after software wrote the holding reg
  output logic formatSelect, // 0 two-wire, 1 clock synchronous
  output logic ackJudgeEnable, // acknowledge judgment enable
  output logic transmitSelect, // transmit mode
  output logic masterMode, // master mode
  output logic transferHalt, // stop continuous transfer
  output logic irq // interrupt, level, active high
);
  localparam logic [3:0] I2C_LAST = 4'(I2C_BITS - 1);
  localparam logic [3:0] SYNC_LAST = 4'(SYNC_BITS - 1);

  if (I2C_BITS < 2 || I2C_BITS > 15 || SYNC_BITS < 2 || SYNC_BITS > 15) begin : g_chk
    $error("frame bit counts must lie in 2..15");
  end

  issf_pin_if pinBus();

  issf_bus_monitor u_monitor (
    .clk(clk),
    .reset(reset),
    .sclPin(sclPin),
    .sdaPin(sdaPin),
    .mon(pinBus.det)
  );

  logic [7:0] status_ff;
  logic [7:0] nxt_status;
  logic [7:0] armed_ff;
  logic [7:0] ctrl_ff;
  logic [7:0] mask_ff;
  logic [7:0] txHold_ff;
  logic [7:0] rxData_ff;
  logic [7:0] rdData_ff;
  logic txWritten_ff;
  logic irq_ff;
  logic [3:0] bitCnt_ff;
  logic frameSeen_ff;
  logic [7:0] setBits;
  logic [7:0] clrBits;
  logic wrStatus;
  logic rdStatus;
  logic wrCtrl;
  logic wrTxHold;
  logic rdRxData;
  logic isSync;
  logic frameEnd;
  logic trsRise;
  logic [3:0] lastCnt;

  assign wrStatus = regWr && regAddr == issf_pkg::STATUS_ADDR;
  assign rdStatus = regRd && regAddr == issf_pkg::STATUS_ADDR;
  assign wrCtrl = regWr && regAddr == issf_pkg::CTRL_ADDR;
  assign wrTxHold = regWr && regAddr == issf_pkg::TX_HOLD_ADDR;
  assign rdRxData = regRd && regAddr == issf_pkg::RX_DATA_ADDR;

  assign formatSelect = ctrl_ff[issf_pkg::CTRL_FS_BIT];
  assign ackJudgeEnable = ctrl_ff[issf_pkg::CTRL_ACK_JUDGE_ENABLE_BIT];
  assign transmitSelect = ctrl_ff[issf_pkg::CTRL_TRS_BIT];
  assign masterMode = ctrl_ff[issf_pkg::CTRL_MST_BIT];
  assign isSync = formatSelect == issf_pkg::FMT_SYNC;

  // control and mask registers
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_ff <= issf_pkg::CTRL_RST;
    end else if (wrCtrl) begin
      ctrl_ff <= regWrData & issf_pkg::CTRL_USED;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mask_ff <= issf_pkg::MASK_RST;
    end else if (regWr && regAddr == issf_pkg::IRQ_MASK_ADDR) begin
      mask_ff <= regWrData & issf_pkg::STATUS_USED;
    end
  end

  assign trsRise = wrCtrl && regWrData[issf_pkg::CTRL_TRS_BIT] && !transmitSelect;

  // transmit holding and receive data registers
  always_ff @(posedge clk) begin
    if (reset) begin
      txHold_ff <= issf_pkg::TX_HOLD_RST;
      txWritten_ff <= 1'b0;
    end else begin
      txWritten_ff <= wrTxHold;
      if (wrTxHold) begin
        txHold_ff <= regWrData;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rxData_ff <= issf_pkg::RX_DATA_RST;
    end else if (rxLoad) begin
      rxData_ff <= rxByte;
    end
  end

  assign txHoldData = txHold_ff;
  assign txHoldWritten = txWritten_ff;

  // frame clock counter; ninth rise in two-wire format is the ack clock
  assign lastCnt = isSync ? SYNC_LAST : I2C_LAST;
  assign frameEnd = pinBus.sclRise && bitCnt_ff == lastCnt;

  always_ff @(posedge clk) begin
    if (reset) begin
      bitCnt_ff <= '0;
    end else if (pinBus.startSeen || pinBus.stopSeen) begin
      bitCnt_ff <= '0;
    end else if (frameEnd) begin
      bitCnt_ff <= '0;
    end else if (pinBus.sclRise) begin
      bitCnt_ff <= bitCnt_ff + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      frameSeen_ff <= 1'b0;
    end else if (pinBus.stopSeen || pinBus.startSeen) begin
      frameSeen_ff <= 1'b0;
    end else if (pinBus.sclRise) begin
      frameSeen_ff <= 1'b1;
    end
  end

  // set conditions
  always_comb begin
    setBits = '0;
    setBits[issf_pkg::TX_HOLDING_EMPTY_BIT] = txHoldToShift | trsRise | startIssued | slaveToTransmit;
    setBits[issf_pkg::TX_END_FLAG_BIT] = frameEnd &&
      (isSync ? transmitSelect : status_ff[issf_pkg::TX_HOLDING_EMPTY_BIT]);
    setBits[issf_pkg::RX_FULL_FLAG_BIT] = rxLoad;
    // ack clock sampled high means no acknowledge
    setBits[issf_pkg::NACK_BIT] = !isSync && frameEnd && transmitSelect &&
      pinBus.sdaLevel && ackJudgeEnable;
    setBits[issf_pkg::STOP_BIT] = pinBus.stopSeen && frameSeen_ff;
    if (isSync) begin
      setBits[issf_pkg::ALOVE_BIT] = frameEnd && !transmitSelect &&
        status_ff[issf_pkg::RX_FULL_FLAG_BIT];
    end else begin
      // the ack clock is excluded: the receiver pulls low while we release
      setBits[issf_pkg::ALOVE_BIT] =
        (masterMode && transmitSelect && pinBus.sclRise && !frameEnd &&
         pinBus.sdaLevel != sdaDriveHigh) ||
        (masterMode && pinBus.startSeen && sdaDriveHigh);
    end
  end

  // clear conditions
  always_comb begin
    clrBits = '0;
    if (wrStatus) begin
      clrBits = armed_ff & ~regWrData;
    end
    if (wrTxHold) begin
      clrBits[issf_pkg::TX_HOLDING_EMPTY_BIT] = 1'b1;
      clrBits[issf_pkg::TX_END_FLAG_BIT] = 1'b1;
    end
    if (rdRxData) begin
      clrBits[issf_pkg::RX_FULL_FLAG_BIT] = 1'b1;
    end
  end

  // a set in the same cycle as a clear wins; writing one adds nothing
  assign nxt_status = ((status_ff & ~clrBits) | setBits) & issf_pkg::STATUS_USED;

  always_ff @(posedge clk) begin
    if (reset) begin
      status_ff <= issf_pkg::STATUS_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // a flag may only be cleared by a status write after software has seen it as one
  always_ff @(posedge clk) begin
    if (reset) begin
      armed_ff <= '0;
    end else if (wrStatus) begin
      armed_ff <= '0;
    end else if (rdStatus) begin
      armed_ff <= armed_ff | status_ff;
    end
  end

  // read port: data only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdData_ff <= issf_pkg::READ_IDLE;
    end else if (regRd) begin
      unique case (regAddr)
        issf_pkg::STATUS_ADDR: rdData_ff <= status_ff;
        issf_pkg::CTRL_ADDR: rdData_ff <= ctrl_ff;
        issf_pkg::TX_HOLD_ADDR: rdData_ff <= txHold_ff;
        issf_pkg::RX_DATA_ADDR: rdData_ff <= rxData_ff;
        issf_pkg::IRQ_MASK_ADDR: rdData_ff <= mask_ff;
        default: rdData_ff <= issf_pkg::READ_IDLE;
      endcase
    end else begin
      rdData_ff <= issf_pkg::READ_IDLE;
    end
  end

  assign regRdData = rdData_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(status_ff & mask_ff);
    end
  end

  assign irq = irq_ff;
  // no-ack only halts when judgment is on
  assign transferHalt = ackJudgeEnable && status_ff[issf_pkg::NACK_BIT];

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  tx_holding_empty_shift_set_a: assert property (
    txHoldToShift |=> status_ff[issf_pkg::TX_HOLDING_EMPTY_BIT])
    else $error("holding-empty not set after shift load");

  tx_holding_empty_start_set_a: assert property (
    (startIssued || slaveToTransmit || trsRise) |=> status_ff[issf_pkg::TX_HOLDING_EMPTY_BIT])
    else $error("holding-empty not set by start or mode change");

  tx_write_clr_a: assert property (
    (wrTxHold && !setBits[issf_pkg::TX_HOLDING_EMPTY_BIT] && !setBits[issf_pkg::TX_END_FLAG_BIT])
    |=> !status_ff[issf_pkg::TX_HOLDING_EMPTY_BIT] && !status_ff[issf_pkg::TX_END_FLAG_BIT])
    else $error("holding write did not clear both flags");

  tx_end_flag_ninth_a: assert property (
    (!isSync && frameEnd && status_ff[issf_pkg::TX_HOLDING_EMPTY_BIT])
    |=> status_ff[issf_pkg::TX_END_FLAG_BIT])
    else $error("tx-end missing at ninth clock");

  tx_end_flag_sync_a: assert property (
    (isSync && frameEnd && transmitSelect) |=> status_ff[issf_pkg::TX_END_FLAG_BIT])
    else $error("tx-end missing after last sync bit");

  rx_full_flag_set_a: assert property (
    rxLoad |=> status_ff[issf_pkg::RX_FULL_FLAG_BIT] && rxData_ff == $past(rxByte))
    else $error("rx-full or rx data wrong after load");

  rx_full_flag_read_clr_a: assert property (
    (rdRxData && !rxLoad) |=> !status_ff[issf_pkg::RX_FULL_FLAG_BIT])
    else $error("rx-full not cleared by data read");

  nack_set_a: assert property (
    (!isSync && frameEnd && transmitSelect && pinBus.sdaLevel && ackJudgeEnable)
    |=> status_ff[issf_pkg::NACK_BIT] ##1 transferHalt)
    else $error("no-ack flag or halt missing");

  nack_ignored_a: assert property (
    !ackJudgeEnable |-> !transferHalt)
    else $error("halt raised with judgment off");

  stop_set_a: assert property (
    (pinBus.stopSeen && frameSeen_ff) |=> status_ff[issf_pkg::STOP_BIT])
    else $error("stop flag not set");

  arb_lost_a: assert property (
    (!isSync && masterMode && transmitSelect && pinBus.sclRise && !frameEnd &&
     pinBus.sdaLevel != sdaDriveHigh) |=> status_ff[issf_pkg::ALOVE_BIT])
    else $error("arbitration loss not flagged");

  overrun_a: assert property (
    (isSync && frameEnd && !transmitSelect && status_ff[issf_pkg::RX_FULL_FLAG_BIT])
    |=> status_ff[issf_pkg::ALOVE_BIT])
    else $error("overrun not flagged");

  stop_clr_only_a: assert property (
    $fell(status_ff[issf_pkg::STOP_BIT]) |->
    $past(wrStatus && armed_ff[issf_pkg::STOP_BIT] && !regWrData[issf_pkg::STOP_BIT]))
    else $error("stop flag cleared without read-then-write");

  write_one_a: assert property (
    (wrStatus && (regWrData & issf_pkg::STATUS_USED) == issf_pkg::STATUS_USED && setBits == '0)
    |=> status_ff == $past(status_ff))
    else $error("writing ones changed the flags");

  read_timing_a: assert property (
    (regRd && regAddr == issf_pkg::STATUS_ADDR) |=> regRdData == $past(status_ff) ##1
    (regRd || regRdData == issf_pkg::READ_IDLE))
    else $error("read data not one cycle after strobe");

  irq_follow_a: assert property (
    (|(status_ff & mask_ff)) |=> irq)
    else $error("interrupt did not follow unmasked flag");

  frame_tx_c: cover property (frameEnd && !isSync && status_ff[issf_pkg::TX_HOLDING_EMPTY_BIT]);
  sync_rx_c: cover property (frameEnd && isSync && !transmitSelect);
  clear_seq_c: cover property (rdStatus ##[1:4] (wrStatus && |clrBits));
  arb_c: cover property (!isSync && setBits[issf_pkg::ALOVE_BIT]);
endmodule : issf_status_flags

//--- issf_bus_model.sv
// Purpose: behavioural peer on the two-wire bus, drives clock and data lines
// Assumes: open-drain lines with pull-ups, so a released line reads high
// Notes: clock stands high between frames; one bit takes 401 ns
`timescale 1ns/1ns
module issf_bus_model (
  output logic sclLine, // bus clock as pulled by the peer
  output logic sdaLine // bus data as pulled by the peer
);
  initial begin
    sclLine = 1'b1;
    sdaLine = 1'b1;
  end

  // only from an idle bus, a low data line here would make a stop first
  task automatic start_cond();
    // keeps pin edges off the core clock edge
    #1;
    sdaLine = 1'b1;
    sclLine = 1'b1;
    #100;
    sdaLine = 1'b0;
    #100;
  endtask : start_cond

  // data changes while clock low, bit ends with clock high
  task automatic send_bit(input logic b);
    #1;
    sclLine = 1'b0;
    #100;
    sdaLine = b;
    #100;
    sclLine = 1'b1;
    #200;
  endtask : send_bit

  task automatic stop_cond();
    #1;
    sclLine = 1'b0;
    #100;
    sdaLine = 1'b0;
    #100;
    sclLine = 1'b1;
    #100;
    sdaLine = 1'b1;
    #100;
  endtask : stop_cond
endmodule : issf_bus_model

//--- tb.sv
// Purpose: self-checking bench of the serial bus status flag block
// Assumes: register read data one cycle after the strobe, flags lag pins by about 4 clk
// Notes: each scenario is its own task; bus peer runs unrelated to clk
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic sdaDriveHigh = 1'b1;
  logic txHoldToShift = 1'b0;
  logic startIssued = 1'b0;
  logic slaveToTransmit = 1'b0;
  logic rxLoad = 1'b0;
  logic [7:0] rxByte = 8'h00;
  logic [7:0] regRdData;
  logic [7:0] txHoldData;
  logic txHoldWritten, formatSelect, ackJudgeEnable, transmitSelect, masterMode;
  logic transferHalt, irq, sclLine, sdaLine, sdaPin;
  int nMismatch = 0;
  int checked = 0;

  // wired-and of the peer and our own data driver
  assign sdaPin = sdaLine & sdaDriveHigh;
  always #25 clk = ~clk;

  issf_bus_model bus (.sclLine(sclLine), .sdaLine(sdaLine));
  issf_status_flags uut (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .sclPin(sclLine), .sdaPin(sdaPin),
    .sdaDriveHigh(sdaDriveHigh), .txHoldToShift(txHoldToShift), .startIssued(startIssued),
    .slaveToTransmit(slaveToTransmit), .rxLoad(rxLoad), .rxByte(rxByte),
    .txHoldData(txHoldData), .txHoldWritten(txHoldWritten), .formatSelect(formatSelect),
    .ackJudgeEnable(ackJudgeEnable), .transmitSelect(transmitSelect),
    .masterMode(masterMode), .transferHalt(transferHalt), .irq(irq));

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      nMismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(regRdData, exp);
  endtask : rd_chk

  // read arms every set bit, the zero write then clears them
  task automatic clear_all(input logic [7:0] exp);
    rd_chk(issf_pkg::STATUS_ADDR, exp);
    wr(issf_pkg::STATUS_ADDR, 8'h00);
    rd_chk(issf_pkg::STATUS_ADDR, 8'h00);
  endtask : clear_all

  task automatic pulse(input int k, input logic [7:0] d);
    @(posedge clk);
    rxByte <= d;
    case (k)
      0: txHoldToShift <= 1'b1;
      1: startIssued <= 1'b1;
      2: slaveToTransmit <= 1'b1;
      default: rxLoad <= 1'b1;
    endcase
    @(posedge clk);
    {txHoldToShift, startIssued, slaveToTransmit, rxLoad} <= 4'h0;
  endtask : pulse

  // synchroniser and detector lag plus the flag update
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask : settle

  task automatic test_reset();
    rd_chk(issf_pkg::STATUS_ADDR, 8'h00);
    rd_chk(issf_pkg::CTRL_ADDR, 8'h00);
    rd_chk(issf_pkg::IRQ_MASK_ADDR, 8'h00);
    rd_chk(issf_pkg::RX_DATA_ADDR, 8'hFF);
    chk(txHoldData, 8'hFF);
    chk({7'h00, irq}, 8'h00);
    wr(3'h5, 8'hFF);
    rd_chk(3'h5, 8'h00);
    wr(issf_pkg::STATUS_ADDR, 8'hFF);
    rd_chk(issf_pkg::STATUS_ADDR, 8'h00);
  endtask : test_reset

  task automatic test_tx_flags();
    pulse(0, 8'h00);
    rd_chk(issf_pkg::STATUS_ADDR, 8'h80);
    wr(issf_pkg::TX_HOLD_ADDR, 8'h5A);
    #1;
    chk({7'h00, txHoldWritten}, 8'h01);
    chk(txHoldData, 8'h5A);
    rd_chk(issf_pkg::STATUS_ADDR, 8'h00);
    pulse(1, 8'h00);
    rd_chk(issf_pkg::STATUS_ADDR, 8'h80);
    clear_all(8'h80);
    pulse(2, 8'h00);
    wr(issf_pkg::STATUS_ADDR, 8'h00);
    rd_chk(issf_pkg::STATUS_ADDR, 8'h80);
    wr(issf_pkg::STATUS_ADDR, 8'hFF);
    rd_chk(issf_pkg::STATUS_ADDR, 8'h80);
    clear_all(8'h80);
  endtask : test_tx_flags

  task automatic test_i2c_frame();
    wr(issf_pkg::IRQ_MASK_ADDR, 8'h08);
    rd_chk(issf_pkg::IRQ_MASK_ADDR, 8'h08);
    wr(issf_pkg::CTRL_ADDR, 8'h06);
    #1;
    chk({4'h0, masterMode, transmitSelect, ackJudgeEnable, formatSelect}, 8'h06);
    rd_chk(issf_pkg::STATUS_ADDR, 8'h80);
    bus.start_cond();
    for (int i = 7; i >= 0; i--) begin
      bus.send_bit(i[0]);
    end
    bus.send_bit(1'b1);
    settle();
    rd_chk(issf_pkg::STATUS_ADDR, 8'hD0);
    chk({7'h00, transferHalt}, 8'h01);
    chk({7'h00, irq}, 8'h00);
    bus.stop_cond();
    settle();
    rd_chk(issf_pkg::STATUS_ADDR, 8'hD8);
    chk({7'h00, irq}, 8'h01);
    wr(issf_pkg::TX_HOLD_ADDR, 8'h00);
    rd_chk(issf_pkg::STATUS_ADDR, 8'h18);
    clear_all(8'h18);
    chk({7'h00, transferHalt}, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(issf_pkg::IRQ_MASK_ADDR, 8'h00);
  endtask : test_i2c_frame

  task automatic test_arbitration();
    wr(issf_pkg::CTRL_ADDR, 8'h00);
    bus.start_cond();
    wr(issf_pkg::CTRL_ADDR, 8'h0C);
    bus.send_bit(1'b0);
    settle();
    rd_chk(issf_pkg::STATUS_ADDR, 8'h84);
    clear_all(8'h84);
    // peer pulls data low on the stop clock while we release: a loss as well
    bus.stop_cond();
    settle();
    rd_chk(issf_pkg::STATUS_ADDR, 8'h0C);
    clear_all(8'h0C);
    // second start raises data first: a stop with no clock since the start
    bus.start_cond();
    bus.start_cond();
    settle();
    rd_chk(issf_pkg::STATUS_ADDR, 8'h04);
    clear_all(8'h04);
    wr(issf_pkg::CTRL_ADDR, 8'h00);
  endtask : test_arbitration

  task automatic test_sync();
    wr(issf_pkg::CTRL_ADDR, 8'h01);
    pulse(3, 8'h3C);
    rd_chk(issf_pkg::STATUS_ADDR, 8'h20);
    rd_chk(issf_pkg::RX_DATA_ADDR, 8'h3C);
    rd_chk(issf_pkg::STATUS_ADDR, 8'h00);
    pulse(3, 8'h77);
    repeat (issf_pkg::SYNC_FRAME_BITS) bus.send_bit(1'b1);
    settle();
    rd_chk(issf_pkg::STATUS_ADDR, 8'h24);
    clear_all(8'h24);
    rd_chk(issf_pkg::RX_DATA_ADDR, 8'h77);
    wr(issf_pkg::CTRL_ADDR, 8'h05);
    rd_chk(issf_pkg::STATUS_ADDR, 8'h80);
    repeat (issf_pkg::SYNC_FRAME_BITS) bus.send_bit(1'b1);
    settle();
    rd_chk(issf_pkg::STATUS_ADDR, 8'hC0);
    clear_all(8'hC0);
    wr(issf_pkg::CTRL_ADDR, 8'h00);
  endtask : test_sync

  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    test_reset();
    test_tx_flags();
    test_i2c_frame();
    test_arbitration();
    test_sync();
    final_report();
  end

  // guards against a hung scenario
  initial begin
    #2000000;
    nMismatch++;
    final_report();
  end
endmodule : tb
